// ---- core/cksel_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - four derived clocks selected independently
// - processor clock divides fast by 2^n
// - usb clock is fast, optionally halved
// - interval source fast, slow, or capture
// - interval prescale of 1 to 4
// - capture source fast or slow, not sleep
// - clock pin from four selectable sources
// - slow clock for wakeup and power sequencing
// - fast oscillator tuned from usb traffic unless usb clock is halved
// - fine offset bits 7:5, reset zero
// - gain, slow bias and freq loaded from factory at boot
// - gain bits 4:0 set offset step
// - slow bit 7 selects low power
// - bias field 00 mid, 01 high
// - slow frequency trim in bits 3:0
// - table 0 gives silicon id at F8/F9 once selected by a write
// - speed codes map to cpu rates
// - capture divider 2, 4, 6, 8
// - interval divider 1 to 4, reset 11
module cksel_top #(
  parameter logic [15:0] SILICON_ID = 16'hA5C3, // arbitrary value
  parameter int WAKE_TICKS = 16,
  parameter int TUNE_EXPECT = cksel_pkg::TUNE_EXPECT,
  parameter int TUNE_TOL = cksel_pkg::TUNE_TOL
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [8:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // oscillator ticks and system state
  input wire logic fast_osc_tick,
  input wire logic slow_osc_tick,
  input wire logic sleep_mode,
  input wire logic suspend_mode,
  input wire logic main_clock_stopped,
  // pins
  input wire logic external_clock_input,
  input wire logic usb_frame_mark,
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  // factory calibration
  input wire logic [4:0] factory_gain,
  input wire logic [6:0] factory_slow,
  // derived clock enables
  output logic processor_clock_en,
  output logic usb_engine_clock_en,
  output logic interval_timer_clock_en,
  output logic capture_timer_clock_en,
  output logic wakeup_pulse,
  output logic power_seq_clock_en,
  // trims to the oscillators
  output cksel_pkg::cksel_fast_trim_t fast_trim,
  output cksel_pkg::cksel_slow_trim_t slow_trim
);

  function automatic logic [7:0] cpu_div(input logic [2:0] speed);
    logic [7:0] d;
    d = 8'h08;
    case (speed)
      3'h0: d = 8'h08;
      3'h1: d = 8'h04;
      3'h2: d = 8'h02;
      3'h3: d = 8'h01;
      3'h4: d = 8'h10;
      3'h5: d = 8'h20;
      3'h6: d = 8'h80;
      default: d = 8'h08;
    endcase
    return d;
  endfunction

  function automatic logic hit(input logic [7:0] cnt, input logic [7:0] lim);
    return cnt >= lim - 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] osc_ctrl0_r;
  logic [7:0] tmr_clk_r;
  logic [1:0] usb_lock_r;
  logic [3:0] clk_cfg_r;
  logic [2:0] tbl_sel_r;
  logic [15:0] tbl_data_r;
  cksel_pkg::cksel_fast_trim_t ftrim_r, ftrim_nxt;
  cksel_pkg::cksel_slow_trim_t strim_r;
  logic boot_pend_r;
  logic [7:0] rd_data_r;

  wire wr_osc = wr_en && addr == cksel_pkg::ADR_OSC_CTRL0;
  wire wr_tmr = wr_en && addr == cksel_pkg::ADR_TMR_CLK;
  wire wr_ftrim = wr_en && addr == cksel_pkg::ADR_FAST_TRIM;
  wire wr_strim = wr_en && addr == cksel_pkg::ADR_SLOW_TRIM;
  wire wr_lock = wr_en && addr == cksel_pkg::ADR_USB_LOCK;
  wire wr_cfg = wr_en && addr == cksel_pkg::ADR_CLK_CFG;
  wire wr_tbl = wr_en && addr == cksel_pkg::ADR_TBL_SEL;

  wire [2:0] cpu_speed = osc_ctrl0_r[2:0];
  wire [1:0] itm_sel = tmr_clk_r[1:0];
  wire [1:0] itm_div = tmr_clk_r[3:2];
  wire [1:0] cap_sel = tmr_clk_r[5:4];
  wire [1:0] cap_div = tmr_clk_r[7:6];
  wire usb_half = clk_cfg_r[0];
  wire [1:0] out_sel = clk_cfg_r[2:1];
  wire filt_en = clk_cfg_r[3];
  wire tune_off = usb_lock_r[0];
  wire fine_only = usb_lock_r[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      osc_ctrl0_r <= cksel_pkg::RST_OSC_CTRL0;
      tmr_clk_r <= cksel_pkg::RST_TMR_CLK;
      usb_lock_r <= cksel_pkg::RST_USB_LOCK;
      clk_cfg_r <= cksel_pkg::RST_CLK_CFG;
    end else if (ce) begin
      if (wr_osc) osc_ctrl0_r <= {2'h0, wr_data[5:0]};
      if (wr_tmr) tmr_clk_r <= wr_data;
      if (wr_lock) usb_lock_r <= wr_data[1:0];
      if (wr_cfg) clk_cfg_r <= wr_data[3:0];
    end
  end

  // slow trim: boot load, then software
  always_ff @(posedge clk) begin
    if (srst) begin
      strim_r <= '0;
      boot_pend_r <= 1'b1;
    end else if (ce) begin
      boot_pend_r <= 1'b0;
      if (boot_pend_r) begin
        strim_r <= {1'b0, factory_slow[5:0]};
      end else if (wr_strim) begin
        strim_r.low_power <= wr_data[7];
        strim_r.bias <= wr_data[5:4];
        strim_r.freq <= wr_data[3:0];
      end
    end
  end

  // table read returns silicon id only after a select write of table 0
  always_ff @(posedge clk) begin
    if (srst) begin
      tbl_sel_r <= 3'h0;
      tbl_data_r <= 16'h0000;
    end else if (ce && wr_tbl) begin
      tbl_sel_r <= wr_data[2:0];
      tbl_data_r <= (wr_data[2:0] == 3'h0) ? SILICON_ID : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and clock input filter
  logic [1:0] ext_sync_r, mark_sync_r;
  logic ext_prev_r, ext_filt_r, mark_prev_r;
  wire ext_s = ext_sync_r[1];
  wire mark_edge = mark_sync_r[1] && !mark_prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_sync_r <= 2'h0;
      mark_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
      ext_filt_r <= 1'b0;
      mark_prev_r <= 1'b0;
    end else if (ce) begin
      ext_sync_r <= {ext_sync_r[0], external_clock_input};
      mark_sync_r <= {mark_sync_r[0], usb_frame_mark};
      ext_prev_r <= ext_s;
      mark_prev_r <= mark_sync_r[1];
      if (!filt_en || ext_s == ext_prev_r) ext_filt_r <= ext_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // derived clocks; limits change only at a period boundary or while capture is off
  logic [7:0] cpu_cnt_r, cpu_lim_r;
  logic usb_ph_r, usb_half_r;
  logic [7:0] cap_cnt_r, cap_lim_r;
  logic [1:0] cap_src_r;
  logic [7:0] itm_cnt_r, itm_lim_r;
  logic [1:0] itm_src_r;
  logic cpu_en_r, usb_en_r, cap_en_r, itm_en_r;

  wire slow_ok = slow_osc_tick && !sleep_mode;
  wire cap_tick = (cap_src_r == cksel_pkg::SRC_FAST) ? fast_osc_tick :
                  (cap_src_r == cksel_pkg::SRC_SLOW) ? slow_ok : 1'b0;
  wire itm_tick = (itm_src_r == cksel_pkg::SRC_FAST) ? fast_osc_tick :
                  (itm_src_r == cksel_pkg::SRC_SLOW) ? slow_ok :
                  (itm_src_r == cksel_pkg::SRC_CAPT) ? cap_en_r : 1'b0;
  wire cpu_wrap = fast_osc_tick && hit(cpu_cnt_r, cpu_lim_r);
  wire cap_wrap = cap_tick && hit(cap_cnt_r, cap_lim_r);
  wire itm_wrap = itm_tick && hit(itm_cnt_r, itm_lim_r);
  wire usb_wrap = fast_osc_tick && (usb_ph_r || !usb_half_r);
  wire [7:0] cap_lim_new = {5'h00, cap_div, 1'b0} + 8'h02;
  wire [7:0] itm_lim_new = {6'h00, itm_div} + 8'h01;

  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_cnt_r <= 8'h00;
      cpu_lim_r <= 8'h08;
      cpu_en_r <= 1'b0;
    end else if (ce) begin
      cpu_en_r <= cpu_wrap;
      if (cpu_wrap) begin
        cpu_cnt_r <= 8'h00;
        cpu_lim_r <= cpu_div(cpu_speed);
      end else if (fast_osc_tick) begin
        cpu_cnt_r <= cpu_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      usb_ph_r <= 1'b0;
      usb_half_r <= 1'b0;
      usb_en_r <= 1'b0;
    end else if (ce) begin
      usb_en_r <= usb_wrap;
      if (usb_wrap) begin
        usb_ph_r <= 1'b0;
        usb_half_r <= usb_half;
      end else if (fast_osc_tick) begin
        usb_ph_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cap_cnt_r <= 8'h00;
      cap_lim_r <= 8'h02;
      cap_src_r <= cksel_pkg::SRC_FAST;
      cap_en_r <= 1'b0;
    end else if (ce) begin
      cap_en_r <= cap_wrap;
      if (cap_wrap || cap_src_r == cksel_pkg::CAP_OFF) begin
        cap_cnt_r <= 8'h00;
        cap_lim_r <= cap_lim_new;
        cap_src_r <= cap_sel;
      end else if (cap_tick) begin
        cap_cnt_r <= cap_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      itm_cnt_r <= 8'h00;
      itm_lim_r <= 8'h04;
      itm_src_r <= cksel_pkg::SRC_FAST;
      itm_en_r <= 1'b0;
    end else if (ce) begin
      itm_en_r <= itm_wrap;
      if (itm_wrap) begin
        itm_cnt_r <= 8'h00;
        itm_lim_r <= itm_lim_new;
        itm_src_r <= itm_sel;
      end else if (itm_tick) begin
        itm_cnt_r <= itm_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock output pin; source switches only while the pin is low
  logic pin_r, pin_oe_r;
  logic [1:0] pin_src_r;
  wire pin_tick = (pin_src_r == cksel_pkg::OUT_FAST) ? fast_osc_tick :
                  (pin_src_r == cksel_pkg::OUT_SLOW) ? slow_ok :
                  (pin_src_r == cksel_pkg::OUT_CPU) ? cpu_en_r : 1'b0;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
      pin_src_r <= cksel_pkg::OUT_EXT;
    end else if (ce) begin
      pin_oe_r <= 1'b1;
      if (!pin_r) pin_src_r <= out_sel;
      if (pin_src_r == cksel_pkg::OUT_EXT) pin_r <= ext_filt_r;
      else if (pin_tick) pin_r <= !pin_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // slow clock duties in suspend and power sequencing
  logic [15:0] wake_cnt_r;
  logic wake_r, seq_en_r;
  wire wake_hit = wake_cnt_r >= 16'(WAKE_TICKS - 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      wake_cnt_r <= 16'h0000;
      wake_r <= 1'b0;
      seq_en_r <= 1'b0;
    end else if (ce) begin
      seq_en_r <= slow_osc_tick && main_clock_stopped;
      wake_r <= suspend_mode && slow_osc_tick && wake_hit;
      if (!suspend_mode) wake_cnt_r <= 16'h0000;
      else if (slow_osc_tick) wake_cnt_r <= wake_hit ? 16'h0000 : wake_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fast oscillator tuning against usb frame marks
  logic [15:0] tune_cnt_r;
  logic tune_armed_r, locked_r, coarse_r;
  wire tune_run = !tune_off && !usb_half_r;
  wire too_fast = tune_cnt_r > 16'(TUNE_EXPECT);
  wire too_slow = tune_cnt_r < 16'(TUNE_EXPECT);
  wire far_off = tune_cnt_r > 16'(TUNE_EXPECT + TUNE_TOL) ||
                 tune_cnt_r < 16'(TUNE_EXPECT - TUNE_TOL);
  wire tune_step = tune_run && tune_armed_r && mark_edge;

  always_comb begin
    ftrim_nxt = ftrim_r;
    if (boot_pend_r) begin
      ftrim_nxt.gain = factory_gain;
      ftrim_nxt.foffset = cksel_pkg::RST_FOFFSET;
    end else if (wr_ftrim) begin
      ftrim_nxt = wr_data;
    end else if (tune_step) begin
      if (too_fast && ftrim_r.foffset != 3'h0) ftrim_nxt.foffset = ftrim_r.foffset - 3'h1;
      else if (too_slow && ftrim_r.foffset != 3'h7) ftrim_nxt.foffset = ftrim_r.foffset + 3'h1;
      else if (far_off && !fine_only && ftrim_r.gain != 5'h00) begin
        ftrim_nxt.gain = ftrim_r.gain - 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ftrim_r <= '0;
      tune_cnt_r <= 16'h0000;
      tune_armed_r <= 1'b0;
      locked_r <= 1'b0;
      coarse_r <= 1'b0;
    end else if (ce) begin
      ftrim_r <= ftrim_nxt;
      if (!tune_run) begin
        tune_armed_r <= 1'b0;
        tune_cnt_r <= 16'h0000;
      end else if (mark_edge) begin
        tune_armed_r <= 1'b1;
        tune_cnt_r <= 16'h0000;
        if (tune_armed_r) begin
          locked_r <= !far_off;
          coarse_r <= far_off && !fine_only;
        end
      end else if (fast_osc_tick && tune_cnt_r != 16'hFFFF) begin
        tune_cnt_r <= tune_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      cksel_pkg::ADR_OSC_CTRL0: rd_mux = osc_ctrl0_r;
      cksel_pkg::ADR_TMR_CLK: rd_mux = tmr_clk_r;
      cksel_pkg::ADR_FAST_TRIM: rd_mux = ftrim_r;
      cksel_pkg::ADR_SLOW_TRIM: rd_mux = {strim_r.low_power, 1'b0, strim_r.bias, strim_r.freq};
      cksel_pkg::ADR_USB_LOCK: rd_mux = {6'h00, usb_lock_r};
      cksel_pkg::ADR_CLK_CFG: rd_mux = {4'h0, clk_cfg_r};
      cksel_pkg::ADR_TBL_SEL: rd_mux = {5'h00, tbl_sel_r};
      cksel_pkg::ADR_STATUS: rd_mux = {5'h00, tune_armed_r, coarse_r, locked_r};
      cksel_pkg::ADR_TBL_B0: rd_mux = tbl_data_r[15:8];
      cksel_pkg::ADR_TBL_B1: rd_mux = tbl_data_r[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) rd_data_r <= 8'h00;
    else if (ce) rd_data_r <= rd_en ? rd_mux : 8'h00;
  end

  assign rd_data = rd_data_r;
  assign clock_output_pin = pin_r;
  assign clock_output_pin_oe = pin_oe_r;
  assign processor_clock_en = cpu_en_r;
  assign usb_engine_clock_en = usb_en_r;
  assign interval_timer_clock_en = itm_en_r;
  assign capture_timer_clock_en = cap_en_r;
  assign wakeup_pulse = wake_r;
  assign power_seq_clock_en = seq_en_r;
  assign fast_trim = ftrim_r;
  assign slow_trim = strim_r;

endmodule

// ---- core/cksel_pkg.sv ----
package cksel_pkg;
  // register offsets
  localparam logic [8:0] ADR_OSC_CTRL0 = 9'h1E0;
  localparam logic [8:0] ADR_TMR_CLK = 9'h031;
  localparam logic [8:0] ADR_FAST_TRIM = 9'h034;
  localparam logic [8:0] ADR_SLOW_TRIM = 9'h036;
  localparam logic [8:0] ADR_USB_LOCK = 9'h039;
  localparam logic [8:0] ADR_CLK_CFG = 9'h03A;
  localparam logic [8:0] ADR_TBL_SEL = 9'h03B;
  localparam logic [8:0] ADR_STATUS = 9'h03C;
  localparam logic [8:0] ADR_TBL_B0 = 9'h0F8;
  localparam logic [8:0] ADR_TBL_B1 = 9'h0F9;
  // reset values
  localparam logic [7:0] RST_OSC_CTRL0 = 8'h00;
  localparam logic [7:0] RST_TMR_CLK = 8'h0C;
  localparam logic [2:0] RST_FOFFSET = 3'h0;
  localparam logic [1:0] RST_USB_LOCK = 2'h0;
  localparam logic [3:0] RST_CLK_CFG = 4'h0;
  // source codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h2;
  localparam logic [1:0] SRC_CAPT = 2'h3;
  localparam logic [1:0] CAP_OFF = 2'h3;
  // clock output sources
  localparam logic [1:0] OUT_EXT = 2'h0;
  localparam logic [1:0] OUT_FAST = 2'h1;
  localparam logic [1:0] OUT_SLOW = 2'h2;
  localparam logic [1:0] OUT_CPU = 2'h3;
  // slow bias code that must not be used
  localparam logic [1:0] BIAS_BAD = 2'h2;
  // fast oscillator nominal and lock window
  localparam int FAST_HZ = 24000000;
  localparam int MARK_US = 1000;
  localparam int TOL_PERMILLE = 15;
  localparam int TUNE_EXPECT = FAST_HZ / 1000 * MARK_US / 1000;
  localparam int TUNE_TOL = TUNE_EXPECT * TOL_PERMILLE / 1000;

  typedef struct packed {
    logic [2:0] foffset;
    logic [4:0] gain;
  } cksel_fast_trim_t;

  typedef struct packed {
    logic low_power;
    logic [1:0] bias;
    logic [3:0] freq;
  } cksel_slow_trim_t;
endpackage

// ---- testbench/cksel_sva.sv ----
`timescale 1ns/1ps
module cksel_sva #(
  parameter logic [15:0] SILICON_ID = 16'hA5C3
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [8:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  // system state
  input wire logic slow_osc_tick,
  input wire logic suspend_mode,
  input wire logic main_clock_stopped,
  input wire logic [4:0] factory_gain,
  input wire logic [6:0] factory_slow,
  // observed outputs
  input wire logic clock_output_pin_oe,
  input wire logic capture_timer_clock_en,
  input wire logic wakeup_pulse,
  input wire logic power_seq_clock_en,
  input wire cksel_pkg::cksel_fast_trim_t fast_trim,
  input wire cksel_pkg::cksel_slow_trim_t slow_trim
);
  logic [2:0] sel_r;
  wire sel_wr = ce && wr_en && addr == cksel_pkg::ADR_TBL_SEL;
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_r <= 3'h0;
    end else if (sel_wr) begin
      sel_r <= wr_data[2:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  property p_boot;
    (ce && $past(srst)) |=> fast_trim == {3'h0, $past(factory_gain)} &&
      slow_trim == {1'b0, $past(factory_slow[5:0])};
  endproperty
  a_boot: assert property (p_boot) else $error("trim boot load wrong");
  property p_oe;
    (ce && !srst) |=> clock_output_pin_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");
  property p_rd_idle;
    (ce && !rd_en) |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_tbl_hi;
    (ce && rd_en && addr == cksel_pkg::ADR_TBL_B0) |=>
      rd_data == (($past(sel_r) == 3'h0) ? SILICON_ID[15:8] : 8'h00);
  endproperty
  a_tbl_hi: assert property (p_tbl_hi) else $error("id upper byte wrong");
  property p_tbl_lo;
    (ce && rd_en && addr == cksel_pkg::ADR_TBL_B1) |=>
      rd_data == (($past(sel_r) == 3'h0) ? SILICON_ID[7:0] : 8'h00);
  endproperty
  a_tbl_lo: assert property (p_tbl_lo) else $error("id lower byte wrong");
  property p_fast_wr;
    (ce && wr_en && addr == cksel_pkg::ADR_FAST_TRIM && !$past(srst)) |=>
      fast_trim == $past(wr_data);
  endproperty
  a_fast_wr: assert property (p_fast_wr) else $error("fast trim write lost");
  property p_slow_wr;
    (ce && wr_en && addr == cksel_pkg::ADR_SLOW_TRIM && !$past(srst)) |=>
      slow_trim == {$past(wr_data[7]), $past(wr_data[5:0])};
  endproperty
  a_slow_wr: assert property (p_slow_wr) else $error("slow trim write lost");
  property p_cap_min;
    (ce && capture_timer_clock_en) |=> !capture_timer_clock_en;
  endproperty
  a_cap_min: assert property (p_cap_min) else $error("capture divide below 2");
  property p_pwr;
    (ce && !srst) |=> power_seq_clock_en == ($past(main_clock_stopped) && $past(slow_osc_tick));
  endproperty
  a_pwr: assert property (p_pwr) else $error("power sequence clock wrong");
  property p_wake_off;
    (!suspend_mode [*2]) |=> !wakeup_pulse;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wakeup outside suspend");
  c_tbl: cover property (rd_en && addr == cksel_pkg::ADR_TBL_B0 && sel_r == 3'h0);
  c_wake: cover property (wakeup_pulse);
  c_pwr: cover property (power_seq_clock_en);
endmodule
bind cksel_top cksel_sva #(.SILICON_ID(SILICON_ID)) cksel_sva_inst (.clk(clk), .srst(srst),
  .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .slow_osc_tick(slow_osc_tick), .suspend_mode(suspend_mode),
  .main_clock_stopped(main_clock_stopped), .factory_gain(factory_gain),
  .factory_slow(factory_slow), .clock_output_pin_oe(clock_output_pin_oe),
  .capture_timer_clock_en(capture_timer_clock_en), .wakeup_pulse(wakeup_pulse),
  .power_seq_clock_en(power_seq_clock_en), .fast_trim(fast_trim), .slow_trim(slow_trim));

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] ID = 16'h5AC3; // arbitrary value
  logic clk = 0;
  logic srst = 1;
  logic wr_en = 0;
  logic rd_en = 0;
  logic fast_on = 1;
  logic slow_on = 0;
  logic fast_osc_tick = 0;
  logic slow_osc_tick = 0;
  logic sleep_mode = 0;
  logic suspend_mode = 0;
  logic mcs = 0;
  logic ext_in = 0;
  logic ce = 1;
  logic frame_mark = 0;
  logic [4:0] factory_gain = 5'h13;
  logic [6:0] factory_slow = 7'h5A;
  logic counting = 0;
  logic pin, pin_oe, pin_q = 0;
  logic [1:0] cyc = 0;
  wire [5:0] en;
  logic [8:0] addr = 0;
  logic [7:0] wr_data = 0;
  logic [7:0] rd_data, got;
  cksel_pkg::cksel_fast_trim_t fast_trim;
  cksel_pkg::cksel_slow_trim_t slow_trim;
  int num_errors = 0;
  int num_checks = 0;
  int cnt[7];
  always #50 clk = ~clk;
  cksel_top #(.SILICON_ID(ID), .WAKE_TICKS(2), .TUNE_EXPECT(20), .TUNE_TOL(2)) cksel_top_inst (
    .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .fast_osc_tick(fast_osc_tick),
    .slow_osc_tick(slow_osc_tick), .sleep_mode(sleep_mode), .suspend_mode(suspend_mode),
    .main_clock_stopped(mcs), .external_clock_input(ext_in), .usb_frame_mark(frame_mark),
    .clock_output_pin(pin), .clock_output_pin_oe(pin_oe), .factory_gain(factory_gain),
    .factory_slow(factory_slow), .processor_clock_en(en[0]), .usb_engine_clock_en(en[1]),
    .interval_timer_clock_en(en[2]), .capture_timer_clock_en(en[3]), .wakeup_pulse(en[4]),
    .power_seq_clock_en(en[5]), .fast_trim(fast_trim), .slow_trim(slow_trim));
  // oscillator ticks and pulse counting
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    fast_osc_tick <= fast_on;
    slow_osc_tick <= slow_on && cyc == 2'h3;
    if (counting) begin
      for (int i = 0; i < 6; i++) cnt[i] += int'(en[i] === 1'b1);
      cnt[6] += int'(pin === 1'b1 && pin_q === 1'b0);
    end
    pin_q <= pin;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask
  task automatic measure(input int settle, input int win);
    repeat (settle) @(posedge clk);
    #1;
    foreach (cnt[i]) cnt[i] = 0;
    counting = 1;
    repeat (win) @(posedge clk);
    #1;
    counting = 0;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot(input logic [7:0] eg, input logic [7:0] es);
    rd(cksel_pkg::ADR_FAST_TRIM, got);
    chk(got, eg);
    rd(cksel_pkg::ADR_SLOW_TRIM, got);
    chk(got, es);
    rd(cksel_pkg::ADR_TMR_CLK, got);
    chk(got, 8'h0C);
    rd(cksel_pkg::ADR_TMR_CLK, got);
    chk(got, 8'h0C);
    rd(cksel_pkg::ADR_OSC_CTRL0, got);
    chk(got, 8'h00);
    chk({7'h00, pin_oe}, 8'h01);
  endtask
  task automatic t_trim();
    wr(cksel_pkg::ADR_FAST_TRIM, 8'hE7);
    rd(cksel_pkg::ADR_FAST_TRIM, got);
    chk(got, 8'hE7);
    chk(fast_trim, 8'hE7);
    wr(cksel_pkg::ADR_SLOW_TRIM, 8'hDA);
    rd(cksel_pkg::ADR_SLOW_TRIM, got);
    chk(got, 8'h9A);
    chk({1'b0, slow_trim}, 8'h5A);
    wr(cksel_pkg::ADR_SLOW_TRIM, 8'h1A);
    rd(cksel_pkg::ADR_SLOW_TRIM, got);
    chk(got, 8'h1A);
    wr(9'h100, 8'hFF);
    rd(9'h100, got);
    chk(got, 8'h00);
  endtask
  task automatic t_table();
    logic [7:0] sel[3] = '{8'h00, 8'h08, 8'h01};
    foreach (sel[i]) begin
      wr(cksel_pkg::ADR_TBL_SEL, sel[i]);
      rd(cksel_pkg::ADR_TBL_B0, got);
      chk(got, (sel[i][2:0] == 3'h0) ? ID[15:8] : 8'h00);
      rd(cksel_pkg::ADR_TBL_B1, got);
      chk(got, (sel[i][2:0] == 3'h0) ? ID[7:0] : 8'h00);
    end
  endtask
  task automatic t_cpu_usb();
    int dv[8] = '{8, 4, 2, 1, 16, 32, 128, 8};
    for (int c = 0; c < 8; c++) begin
      wr(cksel_pkg::ADR_OSC_CTRL0, 8'(c));
      measure(260, 128);
      chk(8'(cnt[0]), 8'(128 / dv[c]));
    end
    for (int b = 0; b < 2; b++) begin
      wr(cksel_pkg::ADR_CLK_CFG, 8'(b));
      measure(8, 48);
      chk(8'(cnt[1]), 8'(48 >> b));
    end
  endtask
  task automatic t_timers();
    for (int k = 0; k < 4; k++) begin
      wr(cksel_pkg::ADR_TMR_CLK, {2'(k), 2'h0, 2'(k), 2'h0});
      measure(20, 48);
      chk(8'(cnt[3]), 8'(48 / ((k + 1) * 2)));
      chk(8'(cnt[2]), 8'(48 / (k + 1)));
    end
    slow_on <= 1'b1;
    wr(cksel_pkg::ADR_TMR_CLK, 8'h22);
    measure(40, 48);
    chk(8'(cnt[2]), 8'd12);
    chk(8'(cnt[3]), 8'd6);
    sleep_mode <= 1'b1;
    measure(40, 48);
    chk(8'(cnt[2] + cnt[3]), 8'd0);
    sleep_mode <= 1'b0;
    wr(cksel_pkg::ADR_TMR_CLK, 8'h03);
    measure(20, 48);
    chk(8'(cnt[2]), 8'd24);
  endtask
  task automatic t_pin();
    wr(cksel_pkg::ADR_CLK_CFG, 8'h02);
    measure(10, 48);
    chk(8'(cnt[6]), 8'd24);
    wr(cksel_pkg::ADR_CLK_CFG, 8'h04);
    measure(20, 48);
    chk(8'(cnt[6]), 8'd6);
    wr(cksel_pkg::ADR_OSC_CTRL0, 8'h02);
    wr(cksel_pkg::ADR_CLK_CFG, 8'h06);
    measure(40, 48);
    chk(8'(cnt[6]), 8'd12);
    wr(cksel_pkg::ADR_CLK_CFG, 8'h00);
    ext_in <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h00, pin}, 8'h01);
    ext_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h00, pin}, 8'h00);
    // filter on: a one-cycle glitch must not reach the pin
    wr(cksel_pkg::ADR_CLK_CFG, 8'h08);
    ext_in <= 1'b1;
    @(posedge clk);
    ext_in <= 1'b0;
    measure(0, 10);
    chk(8'(cnt[6]), 8'd0);
  endtask
  task automatic t_slow_use();
    suspend_mode <= 1'b1;
    mcs <= 1'b1;
    measure(20, 48);
    chk(8'(cnt[4]), 8'd6);
    chk(8'(cnt[5]), 8'd12);
    suspend_mode <= 1'b0;
    mcs <= 1'b0;
    measure(20, 48);
    chk(8'(cnt[4] + cnt[5]), 8'd0);
  endtask
  // frame marks 19 clocks apart, i.e. 18 fast ticks counted between them
  task automatic marks(input int n);
    repeat (n) begin
      frame_mark <= 1'b1;
      repeat (4) @(posedge clk);
      frame_mark <= 1'b0;
      repeat (15) @(posedge clk);
    end
  endtask
  task automatic t_tune();
    wr(cksel_pkg::ADR_FAST_TRIM, 8'h8F);
    marks(3);
    rd(cksel_pkg::ADR_FAST_TRIM, got);
    chk(got, 8'hCF);
    rd(cksel_pkg::ADR_STATUS, got);
    chk(got, 8'h05);
    wr(cksel_pkg::ADR_USB_LOCK, 8'h01);
    marks(3);
    rd(cksel_pkg::ADR_FAST_TRIM, got);
    chk(got, 8'hCF);
    rd(cksel_pkg::ADR_STATUS, got);
    chk(got, 8'h01);
  endtask
  task automatic t_freeze();
    ce <= 1'b0;
    wr(cksel_pkg::ADR_OSC_CTRL0, 8'h05);
    ce <= 1'b1;
    rd(cksel_pkg::ADR_OSC_CTRL0, got);
    chk(got, 8'h02);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_boot(8'h13, 8'h1A);
    t_trim();
    t_table();
    t_cpu_usb();
    t_timers();
    t_pin();
    t_slow_use();
    t_tune();
    t_freeze();
    @(posedge clk);
    factory_gain <= 5'h0A;
    factory_slow <= 7'h45;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_boot(8'h0A, 8'h05);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
